// file: design/qspi_regs.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  queued serial master sequencer.
  Assumes a 10 MHz aclk and an AXI4-Lite slave with 32-bit aligned words.
*/
// Overview of operation
// RULE1 - Serial clock is aclk over twice divider
// RULE2 - Divider zero stops the serial clock
// RULE3 - Lead delay enable waits lead count cycles; a lead count of zero waits half clock period instead
// RULE4 - Otherwise lead delay is half clock period
// RULE5 - Trail delay enable waits 32 times count
// RULE6 - Trail count zero gives 8192 cycles
// RULE7 - Trail disabled gives standard 17 cycles
// RULE8 - Length select picks 8 or programmed bits
// RULE9 - Run starts at start pointer entry
// RULE10 - Word done: record pointer, advance, reload
// RULE11 - Start pointer rewrite applies after transfer
// RULE12 - Hold select keeps lines, else negate
// RULE13 - Queue end sets flag, irq, stops
// RULE14 - Wrap target is zero or start pointer
// RULE15 - Wrap keeps running, overwrites receive data
// RULE16 - Done flag cleared only by software
// RULE17 - Wrap cleared stops at next queue end
// RULE18 - Stop request finishes word then stops
// RULE19 - Software leaves wrap without clearing run
// RULE20 - Software programs enough inter-transfer delay
// RULE21 - Shift most significant bit first, right-justified
// RULE22 - Short receive words zero-extended in entry
// RULE23 - Polarity sets serial clock idle level
// RULE24 - Command byte carries select line pattern
// RULE25 - Select pattern stable through whole transfer
`ifndef QSPI_REGS_VH
`define QSPI_REGS_VH

`define MODE_OFS      8'h00
`define DELAY_OFS     8'h04
`define WRAP_OFS      8'h08
`define IRQ_OFS       8'h0c
`define RAM_ADDR_OFS  8'h10
`define RAM_DATA_OFS  8'h14

`define CMD_HOLD      7
`define CMD_LEN       6
`define CMD_TRAIL     5
`define CMD_LEAD      4

`define MODE_RST      16'h0000
`define DIV_RST       8'h00
`define DELAY_RST     16'h0000
`define CS_IDLE       4'hf
`define DEF_BITS      5'h08

`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2

`define CLK_HZ        10000000
`define STD_TRAIL_CYC 14'h0011
`define TRAIL_MULT    5
`define TRAIL_ZERO    8192

`endif

// file: design/queued_spi_master_sequencer.v
/*
  Queued serial master: command, transmit and receive queues of 16
  entries, serial clock divider, lead and trail delays, wraparound.
  Assumes an AXI4-Lite master on aclk and peripherals on select lines.
*/
`include "qspi_regs.vh"
`default_nettype none

module queued_spi_master_sequencer #(
  parameter TRAIL_ZERO_CYC = `TRAIL_ZERO
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  // AXI4-Lite read
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // Serial link
  output wire        serial_clock,
  output wire        serial_out,
  input  wire        serial_in,
  output wire [3:0]  select_lines,
  // Queue done request
  output wire        irq
);

  localparam S_IDLE  = 3'h0;
  localparam S_LOAD  = 3'h1;
  localparam S_LEAD  = 3'h2;
  localparam S_SHIFT = 3'h3;
  localparam S_TRAIL = 3'h4;

  reg [15:0] tx_mem  [0:15];
  reg [15:0] rx_mem  [0:15];
  reg [7:0]  cmd_mem [0:15];

  reg        aw_got_q, w_got_q, bvalid_q, rvalid_q;
  reg [7:0]  awa_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;
  reg [1:0]  bresp_q, rresp_q;
  reg [31:0] rdata_q;

  reg [7:0]  baud_q;
  reg        clock_phase_q, clock_polarity_q;
  reg [3:0]  bits_q;
  reg        run_q;
  reg [6:0]  qcd_q;
  reg [7:0]  dtl_q;
  reg [3:0]  queue_end_pointer_q, queue_start_pointer_q, last_done_pointer_q, ptr_q;
  reg        wrap_target_select_q, wrap_enable_q, halt_q, pend_q;
  reg        flag_q, ie_q;
  reg [5:0]  raddr_q;

  reg [2:0]  st_q;
  reg [13:0] cnt_q;
  reg [4:0]  nb_q, e_q;
  reg [15:0] sh_q, rsh_q;
  reg [3:0]  cs_q;
  reg        sck_q, hold_q;
  reg        sdi_m_q, sdi_s_q;

  wire       wr_go = aw_got_q && w_got_q && !bvalid_q;
  wire       rd_go = arvalid && !rvalid_q;
  wire [7:0] cmd = cmd_mem[ptr_q];
  wire       tick = (cnt_q == 14'h0001);
  wire       last = (e_q == (nb_q << 1) - 5'h01);
  wire       fin = (st_q == S_SHIFT) && (baud_q != 8'h00) && tick && last;
  wire       samp = (e_q[0] == clock_phase_q);
  wire [15:0] rx_in = {rsh_q[14:0], sdi_s_q};
  wire [16:0] mask17 = (17'h00001 << nb_q) - 17'h00001;
  wire [15:0] rx_word = (clock_phase_q ? rx_in : rsh_q) & mask17[15:0]; // [RULE22]
  wire [4:0] len = cmd[`CMD_LEN] ?
                   ((bits_q == 4'h0) ? 5'h10 : {1'b0, bits_q}) :
                   `DEF_BITS; // [RULE8]
  // Lead count in aclk cycles from select to the first clock edge
  wire [13:0] lead_n = (cmd[`CMD_LEAD] && qcd_q != 7'h00) ?
                       {7'h00, qcd_q} : {6'h00, baud_q}; // [RULE3] [RULE4]
  // Start pointer writes that change it; a same-value rewrite is ignored
  wire       np_wr = wr_go && awa_q == `WRAP_OFS && ws_q[1] &&
                     (wd_q[11:8] != queue_start_pointer_q); // [RULE11]
  wire       wl = ws_q[0];
  wire       wh = ws_q[1];

  assign awready      = !aw_got_q && !bvalid_q;
  assign wready       = !w_got_q && !bvalid_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = !rvalid_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign serial_clock = sck_q;
  assign serial_out   = sh_q[15]; // [RULE21]
  assign select_lines = cs_q; // [RULE12]
  assign irq          = flag_q && ie_q; // [RULE13]

  // Input sampling of the serial data pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      sdi_m_q <= serial_in;
      sdi_s_q <= sdi_m_q;
    end
  end

  // Software side of transmit and command queues
  always @(posedge aclk) begin
    if (wr_go && awa_q == `RAM_DATA_OFS && wl && wh) begin
      if (raddr_q < 6'h10)
        tx_mem[raddr_q[3:0]] <= wd_q[15:0];
      else if (raddr_q >= 6'h20 && raddr_q < 6'h30)
        cmd_mem[raddr_q[3:0]] <= wd_q[7:0];
    end
  end

  // Receive queue, overwritten on every pass
  always @(posedge aclk) begin
    if (fin)
      rx_mem[ptr_q] <= rx_word; // [RULE9] [RULE15]
  end

  // Bus channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awa_q    <= 8'h00;
      wd_q     <= 32'h00000000;
      ws_q     <= 4'h0;
      bresp_q  <= `AXI_OKAY;
      rresp_q  <= `AXI_OKAY;
      rdata_q  <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awa_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wd_q    <= wdata;
        ws_q    <= wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (awa_q[7:2] > 6'h05 || awa_q[1:0] != 2'h0) ?
                    `AXI_SLVERR : `AXI_OKAY;
      end else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= `AXI_OKAY;
        rdata_q  <= 32'h00000000;
        case (araddr)
          `MODE_OFS:
            rdata_q[15:0] <= {2'h0, bits_q, clock_polarity_q, clock_phase_q, baud_q};
          `DELAY_OFS:
            rdata_q[15:0] <= {run_q, qcd_q, dtl_q};
          `WRAP_OFS:
            rdata_q[15:0] <= {halt_q, st_q != S_IDLE, wrap_enable_q, wrap_target_select_q,
                              queue_start_pointer_q, last_done_pointer_q, queue_end_pointer_q};
          `IRQ_OFS:
            rdata_q[15:0] <= {7'h00, ie_q, 7'h00, flag_q};
          `RAM_ADDR_OFS:
            rdata_q[15:0] <= {10'h000, raddr_q};
          `RAM_DATA_OFS:
            if (raddr_q >= 6'h10 && raddr_q < 6'h20)
              rdata_q[15:0] <= rx_mem[raddr_q[3:0]];
          default:
            rresp_q <= `AXI_SLVERR;
        endcase
      end else if (rvalid_q && rready)
        rvalid_q <= 1'b0;
    end
  end

  // Control registers and queue sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_q  <= `DIV_RST;
      clock_phase_q  <= 1'b0;
      clock_polarity_q  <= 1'b0;
      bits_q  <= 4'h0;
      run_q   <= 1'b0;
      qcd_q   <= 7'h00;
      dtl_q   <= 8'h00;
      queue_end_pointer_q <= 4'h0;
      queue_start_pointer_q <= 4'h0;
      last_done_pointer_q <= 4'h0;
      ptr_q   <= 4'h0;
      wrap_target_select_q  <= 1'b0;
      wrap_enable_q  <= 1'b0;
      halt_q  <= 1'b0;
      pend_q  <= 1'b0;
      flag_q  <= 1'b0;
      ie_q    <= 1'b0;
      raddr_q <= 6'h00;
      st_q    <= S_IDLE;
      cnt_q   <= 14'h0000;
      nb_q    <= `DEF_BITS;
      e_q     <= 5'h00;
      sh_q    <= 16'h0000;
      rsh_q   <= 16'h0000;
      cs_q    <= `CS_IDLE;
      sck_q   <= 1'b0;
      hold_q  <= 1'b0;
    end else begin
      if (rd_go && araddr == `RAM_DATA_OFS)
        raddr_q <= raddr_q + 6'h01;
      if (wr_go) begin
        case (awa_q)
          `MODE_OFS: begin
            if (wl)
              baud_q <= wd_q[7:0];
            if (wh) begin
              clock_phase_q <= wd_q[8];
              clock_polarity_q <= wd_q[9];
              bits_q <= wd_q[13:10];
            end
          end
          `DELAY_OFS: begin
            if (wl)
              dtl_q <= wd_q[7:0];
            if (wh) begin
              qcd_q <= wd_q[14:8];
              run_q <= wd_q[15];
            end
          end
          `WRAP_OFS: begin
            if (wl)
              queue_end_pointer_q <= wd_q[3:0];
            if (wh) begin
              queue_start_pointer_q <= wd_q[11:8];
              wrap_target_select_q  <= wd_q[12];
              wrap_enable_q  <= wd_q[13];
              halt_q  <= wd_q[15];
              if (np_wr && st_q != S_IDLE)
                pend_q <= 1'b1; // [RULE11]
            end
          end
          `IRQ_OFS: begin
            if (wl && wd_q[0])
              flag_q <= 1'b0; // [RULE16]
            if (wh)
              ie_q <= wd_q[8];
          end
          `RAM_ADDR_OFS:
            if (wl)
              raddr_q <= wd_q[5:0];
          `RAM_DATA_OFS:
            raddr_q <= raddr_q + 6'h01;
          default: ;
        endcase
      end
      case (st_q)
        S_IDLE: begin
          cs_q  <= `CS_IDLE;
          sck_q <= clock_polarity_q; // [RULE23]
          if (run_q && !halt_q && baud_q != 8'h00) begin
            ptr_q  <= queue_start_pointer_q; // [RULE9]
            pend_q <= 1'b0;
            st_q   <= S_LOAD;
          end
        end
        S_LOAD: begin
          cs_q   <= cmd[3:0]; // [RULE24]
          hold_q <= cmd[`CMD_HOLD];
          nb_q   <= len;
          sh_q   <= tx_mem[ptr_q] << (5'h10 - len); // [RULE21]
          rsh_q  <= 16'h0000;
          e_q    <= 5'h00;
          sck_q  <= clock_polarity_q;
          cnt_q  <= lead_n; // [RULE3] [RULE4]
          st_q   <= (lead_n == 14'h0001) ? S_SHIFT : S_LEAD;
        end
        // Hands over to the shifter so that its first edge ends the lead
        S_LEAD: begin
          if (cnt_q <= 14'h0002) begin
            cnt_q <= 14'h0001;
            st_q  <= S_SHIFT;
          end else
            cnt_q <= cnt_q - 14'h0001;
        end
        S_SHIFT: begin
          if (baud_q == 8'h00)
            cnt_q <= cnt_q; // [RULE2]
          else if (!tick)
            cnt_q <= cnt_q - 14'h0001;
          else begin
            cnt_q <= {6'h00, baud_q}; // [RULE1]
            sck_q <= ~sck_q;
            e_q   <= e_q + 5'h01;
            if (samp)
              rsh_q <= rx_in;
            else if (!(clock_phase_q && e_q == 5'h00))
              sh_q <= sh_q << 1;
            if (last) begin
              last_done_pointer_q <= ptr_q; // [RULE10]
              sck_q   <= clock_polarity_q;
              if (ptr_q == queue_end_pointer_q) begin
                flag_q <= 1'b1; // [RULE13]
                if (wrap_enable_q)
                  ptr_q <= wrap_target_select_q ? queue_start_pointer_q : 4'h0; // [RULE14] [RULE15]
                else begin
                  run_q <= 1'b0; // [RULE13] [RULE17]
                  ptr_q <= queue_start_pointer_q; // [RULE9]
                end
              end else
                ptr_q <= ptr_q + 4'h1; // [RULE10]
              if (pend_q || np_wr) begin
                ptr_q  <= np_wr ? wd_q[11:8] : queue_start_pointer_q; // [RULE11]
                pend_q <= 1'b0;
              end
              if (!cmd[`CMD_TRAIL])
                cnt_q <= `STD_TRAIL_CYC; // [RULE7]
              else if (dtl_q == 8'h00)
                cnt_q <= TRAIL_ZERO_CYC[13:0]; // [RULE6]
              else
                cnt_q <= {1'b0, dtl_q, 5'h00}; // [RULE5]
              st_q <= S_TRAIL;
            end
          end
        end
        S_TRAIL: begin
          // Select negates one cycle after the last edge, not with it
          if (!hold_q)
            cs_q <= `CS_IDLE; // [RULE12] [RULE25]
          if (!tick)
            cnt_q <= cnt_q - 14'h0001;
          else if (run_q && !halt_q)
            st_q <= S_LOAD;
          else begin
            cs_q <= `CS_IDLE; // [RULE18]
            st_q <= S_IDLE;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
      if (!run_q && st_q != S_IDLE && st_q != S_TRAIL) begin
        cs_q  <= `CS_IDLE;
        sck_q <= clock_polarity_q;
        st_q  <= S_IDLE;
      end
    end
  end

endmodule // queued_spi_master_sequencer

`default_nettype wire

// file: verif/qspi_monitor.sv
/*
  Port checker for the queued serial master.
  Bound to its top module; sees only ports of the aclk domain.
*/
`default_nettype none
module qspi_monitor (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Watched outputs
  input wire logic       bvalid,
  input wire logic       serial_clock,
  input wire logic [3:0] select_lines,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] idle_q;
  logic [7:0] edge_q;
  logic       sclk_q;
  wire        idle = (select_lines == 4'hf);
  // Idle run length and clock edges within a frame
  always @(posedge aclk) begin
    sclk_q <= serial_clock;
    if (!aresetn || idle) edge_q <= 8'h00;
    else edge_q <= edge_q + {7'h00, serial_clock ^ sclk_q};
    if (!aresetn) idle_q <= 8'hff;
    else if (!idle) idle_q <= 8'h00;
    else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
  end
  sequence s_on;
    !idle && $past(idle);
  endsequence
  sequence s_off;
    idle && !$past(idle);
  endsequence
  property p_half;
    $changed(serial_clock) |=> $stable(serial_clock);
  endproperty
  property p_sel;
    $changed(serial_clock) |-> $stable(select_lines);
  endproperty
  property p_lead;
    s_on |-> $stable(serial_clock);
  endproperty
  property p_trail;
    s_on |-> idle_q >= 8'd17;
  endproperty
  property p_edges;
    s_off |-> !edge_q[0] && edge_q >= 8'd16;
  endproperty
  property p_sticky;
    $fell(irq) |-> $rose(bvalid);
  endproperty
  property p_rst;
    $rose(aresetn) |-> idle && !irq && !bvalid;
  endproperty
  property p_quiet;
    idle && $past(idle) && !bvalid && !$past(bvalid)
      |-> $stable(serial_clock);
  endproperty
  a_half: assert property (p_half) else $error("half period short");
  a_sel: assert property (p_sel) else $error("select moved");
  a_lead: assert property (p_lead) else $error("no lead delay");
  a_trail: assert property (p_trail) else $error("trail short");
  a_edges: assert property (p_edges) else $error("edge count");
  a_sticky: assert property (p_sticky) else $error("flag lost");
  a_rst: assert property (p_rst) else $error("reset state");
  a_quiet: assert property (p_quiet) else $error("idle clock");
endmodule // qspi_monitor
bind queued_spi_master_sequencer qspi_monitor mon (.aclk(aclk),
  .aresetn(aresetn), .bvalid(bvalid), .serial_clock(serial_clock),
  .select_lines(select_lines), .irq(irq));
`default_nettype wire

// file: verif/spi_peripheral.sv
/*
  Model peripheral on the serial link, idle-low clock, leading capture.
  Assumes it is selected whenever any select line is low.
*/
`default_nettype none
module spi_peripheral (
  // Serial link
  input  wire logic        serial_clock,
  input  wire logic        serial_out,
  output var  logic        serial_in,
  input  wire logic [3:0]  select_lines,
  // Reply, left-justified, and word heard
  input  wire logic [15:0] reply,
  output var  logic [15:0] heard
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh_q;
  wire         on = (select_lines != 4'hf);
  initial serial_in = 1'b0;
  initial heard = 16'h0000;
  // Released line shows the inverse of its last level
  always @(on) begin
    sh_q = reply;
    serial_in = on ? reply[15] : ~serial_in;
    if (on) heard = 16'h0000;
  end
  always @(posedge serial_clock)
    if (on) heard = {heard[14:0], serial_out};
  always @(negedge serial_clock)
    if (on) begin
      sh_q = sh_q << 1;
      serial_in = sh_q[15];
    end
endmodule // spi_peripheral
`default_nettype wire

// file: verif/tb.sv
/*
  Self-checking bench for the queued serial master.
  Assumes 10 MHz aclk, AXI4-Lite master tasks and a model peripheral.
*/
`default_nettype none
`include "qspi_regs.vh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); \
  end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] reply = 16'h0;
  logic [3:0]  sel_q = 4'hf;
  logic [31:0] d;
  int          num_errors = 0;
  int          compares = 0;
  int          starts = 0;
  wire         awready, wready, bvalid, arready, rvalid, sclk, sout, sin, irq;
  wire  [31:0] rdata;
  wire  [3:0]  sel;
  wire  [15:0] heard;
  always #50 aclk = ~aclk;
  // Frames opened from the deselected state
  always @(posedge aclk) begin
    if (sel != 4'hf && sel_q == 4'hf) starts++;
    sel_q <= sel;
  end
  queued_spi_master_sequencer #(.TRAIL_ZERO_CYC(64)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(), .rvalid(rvalid), .rready(1'b1), .serial_clock(sclk),
    .serial_out(sout), .serial_in(sin), .select_lines(sel), .irq(irq));
  spi_peripheral peer (.serial_clock(sclk), .serial_out(sout),
    .serial_in(sin), .select_lines(sel), .reply(reply), .heard(heard));
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo();
    num_errors++;
    $display("[FAIL] %0t wait timed out", $time);
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic sa, sw, sb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(negedge aclk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      @(posedge aclk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      if (sb) return;
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic sa, sr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(negedge aclk);
      sa = arready;
      sr = rvalid;
      v = rdata;
      @(posedge aclk);
      if (sa) arvalid <= 1'b0;
      if (sr) return;
    end
    tmo();
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic x);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(a, v);
      if (v[b] === x) return;
    end
    tmo();
  endtask
  task automatic ram_wr(input logic [5:0] at, input logic [15:0] v);
    wr(`RAM_ADDR_OFS, {26'h0, at});
    wr(`RAM_DATA_OFS, {16'h0, v});
  endtask
  task automatic ram_rd(input logic [5:0] at);
    wr(`RAM_ADDR_OFS, {26'h0, at});
    rd(`RAM_DATA_OFS, d);
  endtask
  task automatic t_div0();
    wr(`DELAY_OFS, 32'h8000);
    repeat (40) @(negedge aclk);
    `CHK({sclk, sel}, 5'h0f)
    wr(`DELAY_OFS, 32'h0);
  endtask
  task automatic t_single();
    reply <= 16'h5a00;
    ram_wr(6'h00, 16'h3ca5);
    ram_wr(6'h20, 16'h000e);
    wr(`MODE_OFS, 32'h0004);
    wr(`IRQ_OFS, 32'h100);
    wr(`DELAY_OFS, 32'h8000);
    poll(`DELAY_OFS, 15, 1'b0);
    `CHK(heard[7:0], 8'ha5)
    `CHK(irq, 1'b1)
    ram_rd(6'h10);
    `CHK(d[15:0], 16'h005a)
    repeat (30) @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(`IRQ_OFS, 32'h101);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_queue();
    reply <= 16'h9a6c;
    ram_wr(6'h01, 16'hc3e1);
    ram_wr(6'h02, 16'h0f0f);
    ram_wr(6'h21, 16'h00cd);
    ram_wr(6'h22, 16'h004b);
    wr(`WRAP_OFS, 32'h0102);
    starts = 0;
    wr(`DELAY_OFS, 32'h8000);
    poll(`DELAY_OFS, 15, 1'b0);
    `CHK(heard, 16'h0f0f)
    `CHK(starts, 1)
    rd(`WRAP_OFS, d);
    `CHK(d[7:4], 4'h2)
    ram_rd(6'h11);
    `CHK(d[15:0], 16'h9a6c)
    wr(`IRQ_OFS, 32'h101);
  endtask
  task automatic t_wrap();
    ram_wr(6'h03, 16'h0081);
    ram_wr(6'h23, 16'h0027);
    wr(`WRAP_OFS, 32'h3303);
    wr(`DELAY_OFS, 32'h8002);
    poll(`IRQ_OFS, 0, 1'b1);
    rd(`DELAY_OFS, d);
    `CHK(d[15], 1'b1)
    wr(`IRQ_OFS, 32'h101);
    starts = 0;
    poll(`IRQ_OFS, 0, 1'b1);
    `CHK(starts, 1)
    wr(`IRQ_OFS, 32'h101);
    wr(`WRAP_OFS, 32'h1303);
    poll(`DELAY_OFS, 15, 1'b0);
    `CHK(irq, 1'b1)
    rd(`WRAP_OFS, d);
    `CHK(d[7:4], 4'h3)
    wr(`IRQ_OFS, 32'h101);
  endtask
  task automatic t_halt();
    wr(`WRAP_OFS, 32'h3303);
    wr(`DELAY_OFS, 32'h8002);
    for (int i = 0; i < 999 && sel == 4'hf; i++) @(negedge aclk);
    if (sel == 4'hf) tmo();
    wr(`WRAP_OFS, 32'hb303);
    poll(`WRAP_OFS, 14, 1'b0);
    `CHK({sel, heard[7:0]}, 12'hf81)
    rd(`DELAY_OFS, d);
    `CHK(d[15], 1'b1)
    wr(`DELAY_OFS, 32'h0);
    wr(`WRAP_OFS, 32'h0);
    wr(`MODE_OFS, 32'h0204);
    repeat (3) @(negedge aclk);
    `CHK(sclk, 1'b1)
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_div0();
    t_single();
    t_queue();
    t_wrap();
    t_halt();
    conclude();
  end
endmodule // tb
`default_nettype wire
